// *** pm_preload_pkg.sv ***
// Constants and types for the power-management and slot field preloader
package pm_preload_pkg;

    // APB geometry
    localparam int unsigned AW = 12;
    localparam int unsigned DW = 32;
    localparam int unsigned IMG_N = 8;

    // Image word indices; byte address is four times the index
    localparam logic [7:0] IX_LINK2 = 8'h44;
    localparam logic [7:0] IX_CAP0  = 8'h50;
    localparam logic [7:0] IX_DAT0  = 8'h51;
    localparam logic [7:0] IX_CAP1  = 8'h52;
    localparam logic [7:0] IX_DAT1  = 8'h53;
    localparam logic [7:0] IX_CAP2  = 8'h54;
    localparam logic [7:0] IX_DAT2  = 8'h55;
    localparam logic [7:0] IX_SLOT0 = 8'h60;

    // Load order: slot k of the loader walk holds this index
    localparam logic [7:0] IMG_IX [IMG_N] = '{IX_LINK2, IX_CAP0, IX_DAT0,
        IX_CAP1, IX_DAT1, IX_CAP2, IX_DAT2, IX_SLOT0};
    localparam logic [2:0] SLOT_LINK2 = 3'h0;
    localparam logic [2:0] SLOT_P0    = 3'h7;

    // Image reset values
    localparam logic [15:0] RST_CAP = 16'h0030;
    localparam logic [15:0] RST_OTH = 16'h0000;

    // Control, status and configuration window
    localparam logic [AW-1:0] CTRL_A = 12'h000;
    localparam logic [AW-1:0] STAT_A = 12'h004;
    localparam logic [9:0] CFG_PMC  = 10'h040;
    localparam logic [9:0] CFG_PMCS = 10'h044;
    localparam logic [9:0] CFG_LNK  = 10'h08c;
    localparam logic [9:0] CFG_PNUM = 10'h0cc;
    localparam logic [9:0] CFG_SLOT = 10'h0d0;
    localparam logic [9:0] CFG_LPVC = 10'h144;
    localparam logic [9:0] CFG_TCVC = 10'h154;

    // Field positions in image words
    localparam int I_NSR = 0;
    localparam int I_AUX = 1;
    localparam int I_D1  = 4;
    localparam int I_D2  = 5;
    localparam int I_PME = 6;
    localparam int I_PMD = 8;
    localparam int I_CDC = 14;
    localparam int I_SCC = 1;
    localparam int I_DSI = 2;
    localparam int I_LPV = 3;
    localparam int I_PNM = 4;
    localparam int I_TC  = 9;

    // Field positions in configuration dwords
    localparam int P_NSR = 3;
    localparam int P_AUX = 22;
    localparam int P_D1  = 25;
    localparam int P_D2  = 26;
    localparam int P_PME = 28;
    localparam int P_PMD = 24;
    localparam int P_CDC = 8;
    localparam int P_SCC = 28;
    localparam int P_DSI = 21;
    localparam int P_LPV = 4;
    localparam int P_PNM = 24;
    localparam int P_TC  = 1;

    typedef struct packed {
        logic       nsr;
        logic [2:0] aux;
        logic       d1;
        logic       d2;
        logic [1:0] pme;
        logic [7:0] pmd;
    } pm_cfg_t;

    typedef struct packed {
        logic       scc;
        logic       dsi;
        logic       lpvc;
        logic [2:0] pnum;
        logic [6:0] tcmap;
    } p0_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01
    } ld_st_t;

endpackage

// *** pm_slot_vc_field_preload.sv ***
// Preloader copying image words into per-port configuration fields
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module pm_slot_vc_field_preload
    import pm_preload_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [DW-1:0] pwdata,
    output var  logic [DW-1:0] prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    output var  pm_cfg_t       pm_cfg [3],
    output var  p0_cfg_t       p0_cfg,
    output var  logic [1:0]    change_data_count_select,
    output var  logic          cfg_ready
);

    ld_st_t        st_r;
    logic [2:0]    step_r;
    logic          done_r;
    logic [15:0]   img_r [IMG_N];
    pm_cfg_t       pm_r [3];
    p0_cfg_t       p0_r;
    logic [1:0]    cdc_r;
    logic [DW-1:0] prdata_r;
    logic          pready_r;
    logic          pslverr_r;
    logic [DW-1:0] rd_nxt;
    logic          err_nxt;
    logic          hit_img;
    logic [2:0]    isel;
    logic          ld;
    logic          acc;
    logic          fin;
    logic          reload_wr;

    assign ld        = (st_r == ST_LOAD);
    assign acc       = psel & penable;
    assign fin       = acc & pready_r;
    assign reload_wr = fin & pwrite & ~pslverr_r & (paddr == CTRL_A) & pwdata[0];

    // All checks run on pclk and sleep while reset is low
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Loader walk: one image word per cycle, from reset or a reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= ST_LOAD;
            step_r <= 3'h0;
        end else begin
            case (st_r)
                ST_LOAD: begin
                    if (step_r == SLOT_P0) begin
                        st_r <= ST_IDLE;
                    end else begin
                        step_r <= step_r + 3'h1;
                    end
                end
                ST_IDLE: begin
                    if (reload_wr) begin
                        st_r   <= ST_LOAD;
                        step_r <= 3'h0;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Done flag marks fields valid for the switch core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (ld && step_r == SLOT_P0) begin
            done_r <= 1'b1;
        end else if (reload_wr) begin
            done_r <= 1'b0;
        end
    end

    // Image store; writes only land on the completing edge
    for (genvar gi = 0; gi < IMG_N; gi++) begin : g_img
        localparam logic [15:0] RST_V =
            (gi == 1 || gi == 3 || gi == 5) ? RST_CAP : RST_OTH;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                img_r[gi] <= RST_V;
            end else if (fin && pwrite && !pslverr_r && hit_img
                         && isel == 3'(gi)) begin
                img_r[gi] <= pwdata[15:0];
            end
        end
    end

    // Per-port power-management fields, same bit map for every port
    for (genvar gp = 0; gp < 3; gp++) begin : g_port
        localparam logic [2:0] SC = 3'(2 * gp + 1);
        localparam logic [2:0] SD = 3'(2 * gp + 2);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pm_r[gp] <= '0;
            end else if (ld && step_r == SC) begin
                pm_r[gp].nsr <= img_r[SC][I_NSR];
                pm_r[gp].aux <= img_r[SC][I_AUX +: 3];
                pm_r[gp].d1  <= img_r[SC][I_D1];
                pm_r[gp].d2  <= img_r[SC][I_D2];
                pm_r[gp].pme <= img_r[SC][I_PME +: 2];
            end else if (ld && step_r == SD) begin
                pm_r[gp].pmd <= img_r[SD][I_PMD +: 8];
            end
        end

        // Each capability word lands in its own port and leaves the next port alone
        a_cap_slot: assert property (ld && step_r == SC |=>
            pm_r[gp].nsr == img_r[SC][I_NSR] && pm_r[gp].d1 == img_r[SC][I_D1]
            && $stable(pm_r[(gp + 1) % 3]))
            else $error("capability word went to wrong port");
        a_nsr_copy: assert property (ld && step_r == SC |=>
            pm_r[gp].nsr == img_r[SC][I_NSR] && ld && step_r == SC + 3'h1)
            else $error("no soft reset bit not copied");
        a_aux_copy: assert property (ld && step_r == SC |=>
            pm_r[gp].aux == img_r[SC][I_AUX +: 3])
            else $error("aux current not copied");
        a_d1_copy: assert property (ld && step_r == SC |=>
            pm_r[gp].d1 == img_r[SC][I_D1])
            else $error("D1 support bit not copied");
        a_d2_copy: assert property (ld && step_r == SC |=>
            pm_r[gp].d2 == img_r[SC][I_D2])
            else $error("D2 support bit not copied");
        a_pme_copy: assert property (ld && step_r == SC |=>
            pm_r[gp].pme == img_r[SC][I_PME +: 2])
            else $error("event support field not copied");
        a_pmd_copy: assert property (ld && step_r == SD |=>
            pm_r[gp].pmd == img_r[SD][I_PMD +: 8] && $stable(pm_r[gp].aux))
            else $error("data field not copied");
        a_dat_only: assert property (ld && step_r == SD |=>
            $stable(pm_r[gp].nsr) && $stable(pm_r[gp].pme))
            else $error("data word touched capability bits");
        // Fields only move while the loader walks
        a_loaded_hold: assert property (!ld |=> $stable(pm_r[gp]))
            else $error("power fields changed outside a load");
    end

    // Port 2 change-data-count select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cdc_r <= 2'h0;
        end else if (ld && step_r == SLOT_LINK2) begin
            cdc_r <= img_r[SLOT_LINK2][I_CDC +: 2];
        end
    end

    // Port 0 slot, initialization, channel and numbering fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_r <= '0;
        end else if (ld && step_r == SLOT_P0) begin
            p0_r.scc   <= img_r[SLOT_P0][I_SCC];
            p0_r.dsi   <= img_r[SLOT_P0][I_DSI];
            p0_r.lpvc  <= img_r[SLOT_P0][I_LPV];
            p0_r.pnum  <= img_r[SLOT_P0][I_PNM +: 3];
            p0_r.tcmap <= img_r[SLOT_P0][I_TC +: 7];
        end
    end

    // Configuration dword view; bits not held here read zero
    function automatic logic [DW:0] cfg_word(input logic [1:0] p,
                                             input logic [9:0] o);
        logic [DW-1:0] w;
        logic          ok;
        pm_cfg_t       c;
        w  = '0;
        ok = 1'b1;
        c  = pm_r[p];
        case (o)
            CFG_PMC: begin
                w[P_AUX +: 3] = c.aux;
                w[P_D1]       = c.d1;
                w[P_D2]       = c.d2;
                w[P_PME +: 2] = c.pme;
                if (p == 2'd0) begin
                    w[P_DSI] = p0_r.dsi;
                end
            end
            CFG_PMCS: begin
                w[P_NSR]      = c.nsr;
                w[P_PMD +: 8] = c.pmd;
            end
            CFG_LNK: begin
                if (p == 2'd2) begin
                    w[P_CDC +: 2] = cdc_r;
                end
            end
            CFG_PNUM: begin
                ok            = (p == 2'd0);
                w[P_PNM +: 3] = p0_r.pnum;
            end
            CFG_SLOT: begin
                ok       = (p == 2'd0);
                w[P_SCC] = p0_r.scc;
            end
            CFG_LPVC: begin
                ok       = (p == 2'd0);
                w[P_LPV] = p0_r.lpvc;
            end
            CFG_TCVC: begin
                ok           = (p == 2'd0);
                w[P_TC +: 7] = p0_r.tcmap;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        if (!ok) begin
            w = '0;
        end
        return {ok, w};
    endfunction

    // Address decode and read mux
    always_comb begin
        logic [DW:0] cw;
        cw      = '0;
        rd_nxt  = '0;
        err_nxt = 1'b1;
        hit_img = 1'b0;
        isel    = 3'h0;
        for (int i = 0; i < IMG_N; i++) begin
            if (paddr == AW'({IMG_IX[i], 2'b00})) begin
                hit_img = 1'b1;
                isel    = 3'(i);
                err_nxt = 1'b0;
                rd_nxt  = {16'h0000, img_r[i]};
            end
        end
        if (paddr == CTRL_A) begin
            err_nxt = 1'b0;
        end else if (paddr == STAT_A) begin
            err_nxt = pwrite; // Status is read only
            rd_nxt  = {30'h0, done_r, ld};
        end else if (paddr[11:10] != 2'b00) begin
            cw      = cfg_word(paddr[11:10] - 2'b01, paddr[9:0]);
            err_nxt = pwrite | ~cw[DW]; // Configuration view is read only
            rd_nxt  = cw[DW-1:0];
        end
    end

    // APB answer; accesses wait while the loader runs so the host
    // never sees half-loaded fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else if (acc && !pready_r && !ld) begin
            pready_r  <= 1'b1;
            pslverr_r <= err_nxt;
            prdata_r  <= pwrite ? '0 : rd_nxt;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Outputs straight from flops
    assign prdata                   = prdata_r;
    assign pready                   = pready_r;
    assign pslverr                  = pslverr_r;
    assign pm_cfg                   = pm_r;
    assign p0_cfg                   = p0_r;
    assign change_data_count_select = cdc_r;
    assign cfg_ready                = done_r;

    // Load walk as named steps
    sequence s_load_start;
        ld && step_r == 3'h0;
    endsequence

    sequence s_load_end;
        ld && step_r == SLOT_P0 ##1 !ld && done_r;
    endsequence

    // Walk length and bus stall during a load
    a_load_done: assert property (s_load_start |-> ##7 s_load_end)
        else $error("loader did not finish in eight cycles");
    a_load_stall: assert property (ld && acc |=> !pready_r)
        else $error("access answered during load");

    // Port 2 and port 0 field copies on their load steps
    a_cdc_copy: assert property (ld && step_r == SLOT_LINK2 |=>
        cdc_r == img_r[SLOT_LINK2][I_CDC +: 2])
        else $error("change data count select not copied");
    a_scc_copy: assert property (ld && step_r == SLOT_P0 |=>
        p0_r.scc == img_r[SLOT_P0][I_SCC] && done_r)
        else $error("slot clock bit not copied");
    a_dsi_copy: assert property (ld && step_r == SLOT_P0 |=>
        p0_r.dsi == img_r[SLOT_P0][I_DSI])
        else $error("initialization bit not copied");
    a_lpvc_copy: assert property (ld && step_r == SLOT_P0 |=>
        p0_r.lpvc == img_r[SLOT_P0][I_LPV])
        else $error("low priority channel bit not copied");
    a_pnum_copy: assert property (ld && step_r == SLOT_P0 |=>
        p0_r.pnum == img_r[SLOT_P0][I_PNM +: 3])
        else $error("port number not copied");
    a_tcmap_copy: assert property (ld && step_r == SLOT_P0 |=>
        p0_r.tcmap == img_r[SLOT_P0][I_TC +: 7])
        else $error("traffic class map not copied");

    // Answer pulse, error qualifier and reload hand-off
    a_ready_pulse: assert property (pready_r |=> !pready_r)
        else $error("bus answer held for more than one cycle");
    a_err_qual: assert property (pslverr_r |-> pready_r)
        else $error("error flag without an answer");
    a_reload_clear: assert property (reload_wr |=> !done_r ##0 s_load_start)
        else $error("reload did not restart the loader");
    a_done_rise: assert property ($rose(done_r) |-> $past(ld) && !ld)
        else $error("done flag rose outside the last load step");
    a_fields_hold: assert property (!ld |=> $stable(p0_r) && $stable(cdc_r))
        else $error("port fields changed outside a load");

endmodule

`default_nettype wire

// *** apb_host_model.sv ***
// Host-side APB master model that drives the preloader's register bus
`timescale 1ns/1ps
`default_nettype none

module apb_host_model
    import pm_preload_pkg::*;
(
    input  wire logic          pclk,
    output var  logic          psel,
    output var  logic          penable,
    output var  logic          pwrite,
    output var  logic [AW-1:0] paddr,
    output var  logic [DW-1:0] pwdata,
    input  wire logic [DW-1:0] prdata,
    input  wire logic          pready,
    input  wire logic          pslverr
);
    int lost = 0;

    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // Setup, then access held until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] wd,
                        output logic [DW-1:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        // Bounded wait: a stuck slave must not hang the run
        if (n >= 200) begin
            lost++;
            $display("[FAIL] %0t no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

`default_nettype wire

// *** pm_slot_vc_field_preload_tb.sv ***
// Self-checking testbench for the field preloader
`timescale 1ns/1ps
`default_nettype none

module pm_slot_vc_field_preload_tb;
    import pm_preload_pkg::*;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
    logic [DW-1:0] prdata;
    logic          pready;
    logic          pslverr;
    pm_cfg_t       pm_cfg [3];
    p0_cfg_t       p0_cfg;
    logic [1:0]    cdc;
    logic          cfg_ready;
    int            error_cnt = 0;
    int            n_compared = 0;
    logic [DW-1:0] rd;
    logic          err;
    // Image in load order: link2, cap0, dat0, cap1, dat1, cap2, dat2, slot0
    logic [15:0]   dflt [8] = '{16'h0, RST_CAP, 16'h0, RST_CAP, 16'h0, RST_CAP, 16'h0, 16'h0};
    logic [15:0]   pat [8] = '{16'h7fff, 16'h00d3, 16'h5a00, 16'h002c, 16'ha5ff,
                               16'h00ea, 16'h3c00, 16'hab5a};

    pm_slot_vc_field_preload dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pm_cfg(pm_cfg),
        .p0_cfg(p0_cfg), .change_data_count_select(cdc), .cfg_ready(cfg_ready));

    apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    function automatic pm_cfg_t pm_exp(input logic [15:0] c, input logic [15:0] d);
        return {c[0], c[3:1], c[4], c[5], c[7:6], d[15:8]};
    endfunction

    task automatic rdc(input int p, input logic [9:0] o, input logic [31:0] mk,
                       input logic [31:0] e);
        host.xfer(1'b0, 12'(12'h400 * (p + 1)) + {2'b0, o}, '0, rd, err);
        chk({31'h0, err}, 32'h0, "cfg err");
        chk(rd & mk, e, "cfg view");
    endtask

    // Outputs and config view against an image
    task automatic check_fields(input logic [15:0] im [8]);
        pm_cfg_t e;
        logic [15:0] s;
        s = im[7];
        for (int p = 0; p < 3; p++) begin
            e = pm_exp(im[1 + 2 * p], im[2 + 2 * p]);
            chk({16'h0, pm_cfg[p]}, {16'h0, e}, "pm port");
            rdc(p, CFG_PMC, p == 0 ? 32'h37e00000 : 32'h37c00000, {2'b0, e.pme, 1'b0, e.d2,
                e.d1, e.aux, p == 0 ? s[2] : 1'b0, 21'h0});
            rdc(p, CFG_PMCS, 32'hff000008, {e.pmd, 20'h0, e.nsr, 3'h0});
        end
        chk({19'h0, p0_cfg}, {19'h0, s[1], s[2], s[3], s[6:4], s[15:9]}, "p0");
        chk({30'h0, cdc}, {30'h0, im[0][15:14]}, "cdc");
        rdc(2, CFG_LNK, 32'h300, {22'h0, im[0][15:14], 8'h0});
        rdc(0, CFG_PNUM, 32'h07000000, {5'h0, s[6:4], 24'h0});
        rdc(0, CFG_SLOT, 32'h10000000, {3'h0, s[1], 28'h0});
        rdc(0, CFG_LPVC, 32'h10, {27'h0, s[3], 4'h0});
        rdc(0, CFG_TCVC, 32'hfe, {24'h0, s[15:9], 1'b0});
    endtask

    // Request made during the post-reset load is held off until done
    task automatic t_defaults;
        host.xfer(1'b0, STAT_A, '0, rd, err);
        chk({31'h0, cfg_ready}, 32'h1, "ready at answer");
        chk(rd & 32'h3, 32'h2, "status done");
        check_fields(dflt);
        $display("test defaults done");
    endtask

    // Image writes keep low half and leave fields alone until reload
    task automatic t_images;
        for (int k = 0; k < 8; k++) begin
            host.xfer(1'b1, {2'b0, IMG_IX[k], 2'b00}, {16'hffff, pat[k]}, rd, err);
            host.xfer(1'b0, {2'b0, IMG_IX[k], 2'b00}, '0, rd, err);
            chk(rd, {16'h0, pat[k]}, "image readback");
        end
        check_fields(dflt);
        $display("test images done");
    endtask

    // Refused accesses flag an error and change nothing
    task automatic t_refusals;
        logic [AW-1:0] ad [4] = '{12'h440, 12'hffc, 12'h8cc, STAT_A};
        for (int k = 0; k < 4; k++) begin
            host.xfer(k != 1 && k != 2, ad[k], 32'hffffffff, rd, err);
            chk({31'h0, err}, 32'h1, "refused");
        end
        chk({16'h0, pm_cfg[0]}, {16'h0, pm_exp(RST_CAP, 16'h0)}, "no effect");
        chk({31'h0, cfg_ready}, 32'h1, "no reload");
        $display("test refusals done");
    endtask

    // Reload copies the new image into every field
    task automatic t_reload;
        host.xfer(1'b1, CTRL_A, 32'h1, rd, err);
        @(negedge pclk);
        chk({31'h0, cfg_ready}, 32'h0, "load started");
        host.xfer(1'b0, STAT_A, '0, rd, err);
        chk({31'h0, cfg_ready}, 32'h1, "ready at answer");
        chk(rd & 32'h3, 32'h2, "status done");
        check_fields(pat);
        $display("test reload done");
    endtask

    task automatic tally_and_finish;
        error_cnt += host.lost;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_images();
        t_refusals();
        t_reload();
        tally_and_finish();
    end

    // Watchdog, well past the 56 transfers above
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        $display("[FAIL] %0t watchdog", $time);
        tally_and_finish();
    end
endmodule

`default_nettype wire
